// ---- hdl/tbm_tx_backplane_mux_demux.sv ----
// The implementer's own choices: the address-and-strobe port and the address map.
`default_nettype none

module tbm_tx_backplane_mux_demux (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [tbm_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [tbm_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [tbm_pkg::DATA_W-1:0] reg_rdata_o,
    input wire logic tx_serial_clock_i,
    input wire logic tx_multiframe_sync_or_hs_clock_i,
    input wire logic tx_frame_sync_i,
    input wire logic tx_serial_data_in_i,
    output logic [tbm_pkg::NUM_CH-1:0] line_bit_o,
    output logic [tbm_pkg::NUM_CH-1:0] line_bit_valid_o,
    output logic line_frame_o,
    output logic line_superframe_o
);
    typedef struct packed {
        logic [1:0] speed;
        logic mux_en;
        logic sf_sel;
        logic frame_seen;
        logic sclk_seen;
        logic [7:0] frame_cnt;
        logic tog_d;
        logic sclk_d;
        logic [tbm_pkg::DATA_W-1:0] rdata;
    } tbm_ctl_t;

    typedef struct packed {
        logic d_s;
        logic fs_s;
        logic [1:0] run;
        logic [tbm_pkg::CNT_W-1:0] cnt;
        logic [tbm_pkg::NUM_CH-1:0] bits;
        logic [tbm_pkg::NUM_CH-1:0] valid;
        logic fmark;
        logic sfmark;
        logic toggle;
        logic [3:0] cfg_prev;
        logic [3:0] cfg;
    } tbm_link_t;

    tbm_ctl_t c;
    tbm_ctl_t next_c;
    tbm_link_t l;
    tbm_link_t next_l;

    logic [1:0] ctl_sync_q;
    logic [3:0] link_cfg_q;
    logic [1:0] cfg_mode;
    logic cfg_en;
    logic cfg_sf;
    logic byte_mode;
    logic [1:0] lead;
    logic fstart;
    logic [1:0] ch;
    logic frame_evt;
    logic sclk_evt;
    logic [tbm_pkg::DATA_W-1:0] rd_val;
    logic ctrl_wr;
    logic status_wr;

    // Configuration into the link clock domain
    tbm_sync #(
        .WIDTH(4)
    ) u_cfg_sync (
        .clk_i(tx_multiframe_sync_or_hs_clock_i),
        .resetn_i(resetn_i),
        .d_i({c.sf_sel, c.mux_en, c.speed}),
        .q_o(link_cfg_q)
    );

    // Frame toggle and serial clock pin into the register clock domain
    tbm_sync #(
        .WIDTH(2)
    ) u_ctl_sync (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .d_i({l.toggle, tx_serial_clock_i}),
        .q_o(ctl_sync_q)
    );

    assign cfg_mode = l.cfg[1:0];
    assign cfg_en = l.cfg[2];
    assign cfg_sf = l.cfg[3];

    // Register side
    always_comb begin
        next_c = c;
        ctrl_wr = reg_wr_i && (reg_addr_i == tbm_pkg::CTRL_ADDR);
        status_wr = reg_wr_i && (reg_addr_i == tbm_pkg::STATUS_ADDR);
        frame_evt = ctl_sync_q[1] ^ c.tog_d;
        sclk_evt = ctl_sync_q[0] && !c.sclk_d;
        next_c.tog_d = ctl_sync_q[1];
        next_c.sclk_d = ctl_sync_q[0];
        if (ctrl_wr) begin
            next_c.speed =
                reg_wdata_i[tbm_pkg::SPEED_MSB:tbm_pkg::SPEED_LSB];
            next_c.mux_en = reg_wdata_i[tbm_pkg::MUX_EN_BIT];
        end
        if (reg_wr_i && (reg_addr_i == tbm_pkg::SYNC_CFG_ADDR)) begin
            next_c.sf_sel = reg_wdata_i[tbm_pkg::SF_SEL_BIT];
        end
        // Write one clears; a new event wins over the clear
        next_c.frame_seen = (c.frame_seen &&
            !(status_wr && reg_wdata_i[tbm_pkg::FRAME_SEEN_BIT])) ||
            frame_evt;
        next_c.sclk_seen = (c.sclk_seen &&
            !(status_wr && reg_wdata_i[tbm_pkg::SCLK_SEEN_BIT])) ||
            sclk_evt;
        if (frame_evt) begin
            next_c.frame_cnt = 8'(c.frame_cnt + 8'h01);
        end
        rd_val = '0;
        case (reg_addr_i)
            tbm_pkg::CTRL_ADDR: begin
                rd_val[tbm_pkg::SPEED_MSB:tbm_pkg::SPEED_LSB] = c.speed;
                rd_val[tbm_pkg::MUX_EN_BIT] = c.mux_en;
            end
            tbm_pkg::SYNC_CFG_ADDR: begin
                rd_val[tbm_pkg::SF_SEL_BIT] = c.sf_sel;
            end
            tbm_pkg::STATUS_ADDR: begin
                rd_val[tbm_pkg::FRAME_SEEN_BIT] = c.frame_seen;
                rd_val[tbm_pkg::SCLK_SEEN_BIT] = c.sclk_seen;
            end
            tbm_pkg::FRAME_CNT_ADDR: begin
                rd_val = c.frame_cnt;
            end
            default: begin
                rd_val = '0;
            end
        endcase
        next_c.rdata = reg_rd_i ? rd_val : '0;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            c <= '0;
            c.speed <= tbm_pkg::SPEED_RESET;
            c.mux_en <= tbm_pkg::MUX_EN_RESET;
            c.sf_sel <= tbm_pkg::SF_SEL_RESET;
        end else begin
            c <= next_c;
        end
    end

    // Link side
    always_comb begin
        next_l = l;
        // Config word taken only once two link samples agree
        next_l.cfg_prev = link_cfg_q;
        if (link_cfg_q == l.cfg_prev) begin
            next_l.cfg = link_cfg_q;
        end
        next_l.d_s = tx_serial_data_in_i;
        next_l.fs_s = tx_frame_sync_i;
        byte_mode = (cfg_mode == tbm_pkg::MODE_HMVIP) ||
            (cfg_mode == tbm_pkg::MODE_H100);
        case (cfg_mode)
            tbm_pkg::MODE_H100: lead = tbm_pkg::LEAD_H100;
            tbm_pkg::MODE_HMVIP: lead = tbm_pkg::LEAD_HMVIP;
            default: lead = tbm_pkg::LEAD_BIT;
        endcase
        if (!l.fs_s) begin
            next_l.run = '0;
        end else if (l.run != tbm_pkg::RUN_MAX) begin
            next_l.run = 2'(l.run + 2'h1);
        end
        fstart = l.fs_s && (l.run == lead);
        if (fstart) begin
            ch = '0;
        end else if (byte_mode) begin
            ch = l.cnt[tbm_pkg::BYTE_CH_LSB +: 2];
        end else begin
            ch = l.cnt[tbm_pkg::BIT_CH_LSB +: 2];
        end
        next_l.cnt = fstart ? tbm_pkg::CNT_AFTER_START :
            tbm_pkg::CNT_W'(l.cnt + 5'h01);
        next_l.valid = '0;
        next_l.fmark = 1'b0;
        next_l.sfmark = 1'b0;
        if (cfg_en) begin
            next_l.valid[ch] = 1'b1;
            next_l.bits[ch] = l.d_s;
            next_l.fmark = fstart && !cfg_sf;
            next_l.sfmark = fstart && cfg_sf;
            next_l.toggle = l.toggle ^ fstart;
        end
    end

    // link logic on high speed clock
    always_ff @(posedge tx_multiframe_sync_or_hs_clock_i or
            negedge resetn_i) begin
        if (!resetn_i) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    assign reg_rdata_o = c.rdata;
    assign line_bit_o = l.bits;
    assign line_bit_valid_o = l.valid;
    assign line_frame_o = l.fmark;
    assign line_superframe_o = l.sfmark;

    property p_mode_rw;
        @(posedge clk_i) disable iff (!resetn_i)
        (reg_wr_i && reg_addr_i == tbm_pkg::CTRL_ADDR) ##1
        (reg_rd_i && reg_addr_i == tbm_pkg::CTRL_ADDR) |=>
        reg_rdata_o[1:0] == $past(reg_wdata_i[1:0], 2);
    endproperty
    a_mode_rw: assert property (p_mode_rw)
        else $error("mode field readback differs from written value");

    property p_disabled_idle;
        @(posedge tx_multiframe_sync_or_hs_clock_i) disable iff (!resetn_i)
        !cfg_en |=> line_bit_valid_o == 4'h0;
    endproperty
    a_disabled_idle: assert property (p_disabled_idle)
        else $error("channel output while multiplexing is off");

    property p_frame_ch0;
        @(posedge tx_multiframe_sync_or_hs_clock_i) disable iff (!resetn_i)
        (cfg_en && fstart) |=> line_bit_valid_o == 4'h1;
    endproperty
    a_frame_ch0: assert property (p_frame_ch0)
        else $error("frame start did not go to channel 0");

    property p_bit_rotate;
        @(posedge tx_multiframe_sync_or_hs_clock_i) disable iff (!resetn_i)
        (cfg_en && !byte_mode && !fstart && l.cnt[1:0] == 2'h1) ##1
        (cfg_en && !byte_mode && !fstart) |->
        line_bit_valid_o == 4'h2 ##1 line_bit_valid_o == 4'h4;
    endproperty
    a_bit_rotate: assert property (p_bit_rotate)
        else $error("bit mode channel order wrong");

    property p_bit_sync;
        @(posedge tx_multiframe_sync_or_hs_clock_i) disable iff (!resetn_i)
        (cfg_en && cfg_mode == tbm_pkg::MODE_BIT_16M && $rose(l.fs_s))
        |=> (line_frame_o || line_superframe_o);
    endproperty
    a_bit_sync: assert property (p_bit_sync)
        else $error("bit mode frame start not on first sync bit");

    property p_byte_hold;
        @(posedge tx_multiframe_sync_or_hs_clock_i) disable iff (!resetn_i)
        (cfg_en && byte_mode && !fstart && l.cnt == 5'h08) |=>
        line_bit_valid_o == 4'h2;
    endproperty
    a_byte_hold: assert property (p_byte_hold)
        else $error("byte mode did not move to channel 1 after 8 bits");

    property p_h100_align;
        @(posedge tx_multiframe_sync_or_hs_clock_i) disable iff (!resetn_i)
        (cfg_en && cfg_mode == tbm_pkg::MODE_H100 && l.fs_s &&
        $past(l.fs_s) && !$past(l.fs_s, 2)) |=>
        (line_frame_o || line_superframe_o);
    endproperty
    a_h100_align: assert property (p_h100_align)
        else $error("H.100 frame start not on second sync bit");

    property p_capture;
        @(posedge tx_multiframe_sync_or_hs_clock_i) disable iff (!resetn_i)
        line_bit_valid_o[0] |-> line_bit_o[0] ==
        $past(tx_serial_data_in_i, 2);
    endproperty
    a_capture: assert property (p_capture)
        else $error("channel 0 bit differs from captured data");

    property p_superframe;
        @(posedge tx_multiframe_sync_or_hs_clock_i) disable iff (!resetn_i)
        (cfg_en && fstart && cfg_sf) |=>
        (line_superframe_o && !line_frame_o);
    endproperty
    a_superframe: assert property (p_superframe)
        else $error("superframe selection not followed");

    property p_hs_clock_marks;
        @(posedge tx_multiframe_sync_or_hs_clock_i) disable iff (!resetn_i)
        (line_frame_o || line_superframe_o) |-> line_bit_valid_o == 4'h1;
    endproperty
    a_hs_clock_marks: assert property (p_hs_clock_marks)
        else $error("frame mark without channel 0 bit");

    property p_bit12_sync;
        @(posedge tx_multiframe_sync_or_hs_clock_i) disable iff (!resetn_i)
        (cfg_en && cfg_mode == tbm_pkg::MODE_BIT_12M && $rose(l.fs_s))
        |=> (line_frame_o || line_superframe_o);
    endproperty
    a_bit12_sync: assert property (p_bit12_sync)
        else $error("bit mode frame start not on the sync bit");

    property p_hmvip_align;
        @(posedge tx_multiframe_sync_or_hs_clock_i) disable iff (!resetn_i)
        (cfg_en && cfg_mode == tbm_pkg::MODE_HMVIP && l.fs_s &&
        $past(l.fs_s) && $past(l.fs_s, 2) && !$past(l.fs_s, 3)) |=>
        (line_frame_o || line_superframe_o);
    endproperty
    a_hmvip_align: assert property (p_hmvip_align)
        else $error("HMVIP frame start not on third sync bit");

    property p_byte_last_ch;
        @(posedge tx_multiframe_sync_or_hs_clock_i) disable iff (!resetn_i)
        (cfg_en && byte_mode && !fstart && l.cnt == 5'h18) |=>
        line_bit_valid_o == 4'h8;
    endproperty
    a_byte_last_ch: assert property (p_byte_last_ch)
        else $error("byte mode did not reach channel 3 after 24 bits");

    property p_single_frame;
        @(posedge tx_multiframe_sync_or_hs_clock_i) disable iff (!resetn_i)
        (cfg_en && fstart && !cfg_sf) |=>
        (line_frame_o && !line_superframe_o);
    endproperty
    a_single_frame: assert property (p_single_frame)
        else $error("single frame selection not followed");

    property p_rdata_idle;
        @(posedge clk_i) disable iff (!resetn_i)
        !reg_rd_i |=> reg_rdata_o == '0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside the answer cycle");
endmodule : tbm_tx_backplane_mux_demux

`default_nettype wire

// ---- hdl/tbm_pkg.sv ----
// How it works
// - A separate enable bit picks multiplexed operation; the mode field takes its multiplexed meaning only while that bit is 1.
// - Mode 00 takes a 12.352 Mbit/s four-channel stream and splits it bit by bit into channels 0 to 3.
// - Mode 01 takes a 16.384 Mbit/s four-channel stream and splits it bit by bit into channels 0 to 3.
// - Mode 10 takes a 16.384 Mbit/s four-channel stream and splits it byte by byte into channels 0 to 3.
// - Mode 11 takes a 16.384 Mbit/s four-channel stream and splits it byte by byte into channels 0 to 3.
// - The multiframe sync pin carries the high speed clock that the source drives and that clocks the data in.
// - A configuration bit says whether frame sync marks a single frame or a superframe.
// - Serial data is captured on the rising edge of the high speed clock.
// - The two-bit mode field is readable and writable and resets to 00.
`default_nettype none

package tbm_pkg;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned NUM_CH = 4;
    localparam int unsigned CNT_W = 5;

    localparam logic [ADDR_W-1:0] SYNC_CFG_ADDR = 16'h0109;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 16'h0120;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 16'h0121;
    localparam logic [ADDR_W-1:0] FRAME_CNT_ADDR = 16'h0122;

    localparam int unsigned SPEED_LSB = 0;
    localparam int unsigned SPEED_MSB = 1;
    localparam int unsigned MUX_EN_BIT = 2;
    localparam int unsigned SF_SEL_BIT = 5;
    localparam int unsigned FRAME_SEEN_BIT = 0;
    localparam int unsigned SCLK_SEEN_BIT = 1;

    localparam logic [1:0] SPEED_RESET = 2'h0;
    localparam logic MUX_EN_RESET = 1'h0;
    localparam logic SF_SEL_RESET = 1'h0;

    localparam logic [1:0] MODE_BIT_12M = 2'h0;
    localparam logic [1:0] MODE_BIT_16M = 2'h1;
    localparam logic [1:0] MODE_HMVIP = 2'h2;
    localparam logic [1:0] MODE_H100 = 2'h3;

    // Sync bits seen high before the first bit of a frame
    localparam logic [1:0] LEAD_BIT = 2'h0;
    localparam logic [1:0] LEAD_H100 = 2'h1;
    localparam logic [1:0] LEAD_HMVIP = 2'h2;
    localparam logic [1:0] RUN_MAX = 2'h3;

    localparam logic [CNT_W-1:0] CNT_AFTER_START = 5'h01;
    localparam int unsigned BIT_CH_LSB = 0;
    localparam int unsigned BYTE_CH_LSB = 3;
endpackage : tbm_pkg

`default_nettype wire

// ---- hdl/tbm_sync.sv ----
`default_nettype none

module tbm_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] q;
    } tbm_sync_t;

    tbm_sync_t s;
    tbm_sync_t next_s;

    if (WIDTH < 1) begin : g_check
        $error("tbm_sync needs WIDTH of at least 1");
    end

    always_comb begin
        next_s.meta = d_i;
        next_s.q = s.meta;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q_o = s.q;
endmodule : tbm_sync

`default_nettype wire

// ---- tb/tbm_backplane_source.sv ----
`default_nettype none

module tbm_backplane_source (
    output logic hs_clk_o,
    output logic sclk_o,
    output logic sync_o,
    output logic data_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        hs_clk_o = 1'b0;
        sclk_o = 1'b0;
        sync_o = 1'b0;
        data_o = 1'b0;
    end

    always #324 sclk_o = ~sclk_o;

    // one high speed clock per bit, data set up on the low phase
    task automatic edge_out(input logic s, input logic d);
        sync_o = s;
        data_o = d;
        #62.5 hs_clk_o = 1'b1;
        #62.5 hs_clk_o = 1'b0;
    endtask : edge_out

    // Lead is the count of sync bits that belong to the previous frame
    task automatic send_frame(input logic [1:0] lead, input logic [63:0] pat);
        int i;
        int in_high;
        in_high = (lead == 2'h0) ? 1 : int'(lead);
        for (i = 0; i < 6; i++) begin
            edge_out(1'b0, i[0]);
        end
        // sync high over the tail of the previous frame
        for (i = 0; i < int'(lead); i++) begin
            edge_out(1'b1, ~i[0]);
        end
        // sync high over the head of this frame
        for (i = 0; i < 64; i++) begin
            edge_out(i < in_high, pat[63-i]);
        end
        for (i = 0; i < 4; i++) begin
            edge_out(1'b0, ~data_o);
        end
        // Clock stops; released lines must not keep the last value
        sync_o = ~sync_o;
        data_o = ~data_o;
    endtask : send_frame
endmodule : tbm_backplane_source

`default_nettype wire

// ---- tb/tb_tx_backplane_mux_demux.sv ----
`default_nettype none

module tb_tx_backplane_mux_demux;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [63:0] PAT = 64'hA5C3_0FF0_1234_9ABC;
    logic clk_i;
    logic resetn_i;
    logic [tbm_pkg::ADDR_W-1:0] reg_addr_i;
    logic [tbm_pkg::DATA_W-1:0] reg_wdata_i;
    logic reg_wr_i;
    logic reg_rd_i;
    logic [tbm_pkg::DATA_W-1:0] reg_rdata_o;
    logic hs_clk;
    logic sclk;
    logic sync;
    logic sdata;
    logic [3:0] line_bit_o;
    logic [3:0] line_bit_valid_o;
    logic line_frame_o;
    logic line_superframe_o;
    logic [7:0] rd;
    logic [3:0] got_ch [64];
    logic got_bit [64];
    logic [1:0] got_mark;
    int fail_count;
    int checked;
    int nrec;
    int vcount;

    tbm_tx_backplane_mux_demux i_dut (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o),
        .tx_serial_clock_i(sclk),
        .tx_multiframe_sync_or_hs_clock_i(hs_clk),
        .tx_frame_sync_i(sync),
        .tx_serial_data_in_i(sdata),
        .line_bit_o(line_bit_o),
        .line_bit_valid_o(line_bit_valid_o),
        .line_frame_o(line_frame_o),
        .line_superframe_o(line_superframe_o)
    );

    tbm_backplane_source i_src (
        .hs_clk_o(hs_clk),
        .sclk_o(sclk),
        .sync_o(sync),
        .data_o(sdata)
    );

    always #4 clk_i = ~clk_i;

    // Samples link outputs half a link period after they change
    always @(negedge hs_clk) begin
        if (|line_bit_valid_o) begin
            vcount++;
        end
        if (line_frame_o === 1'b1 || line_superframe_o === 1'b1) begin
            nrec = 0;
            got_mark = {line_superframe_o, line_frame_o};
        end
        if (nrec < 64 && |line_bit_valid_o) begin
            got_ch[nrec] = line_bit_valid_o;
            got_bit[nrec] = |(line_bit_o & line_bit_valid_o);
            nrec++;
        end
    end

    task automatic report(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask : report

    task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
        report(got, exp);
    endtask : check_reg

    task automatic check_bit(input logic [3:0] got, input logic [3:0] exp);
        report({4'h0, got}, {4'h0, exp});
    endtask : check_bit

    task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask : reg_write

    // Called right after a clock edge, so a read may follow a write at once
    task automatic reg_read(input logic [15:0] a, output logic [7:0] d);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask : reg_read

    task automatic run(input logic [1:0] m, input logic sf);
        int k;
        int ch;
        reg_write(tbm_pkg::SYNC_CFG_ADDR, {2'h0, sf, 5'h00});
        reg_write(tbm_pkg::CTRL_ADDR, {5'h00, 1'b1, m});
        for (k = 0; k < 64; k++) begin
            got_ch[k] = 'x;
        end
        got_mark = 'x;
        nrec = 64;
        i_src.send_frame(m == 2'h2 ? 2'h2 : {1'b0, m == 2'h3}, PAT);
        check_bit({2'h0, got_mark}, sf ? 4'h2 : 4'h1);
        for (k = 0; k < 64; k++) begin
            ch = m[1] ? (k / 8) % 4 : k % 4;
            check_bit(got_ch[k], 4'h1 << ch);
            check_bit({3'h0, got_bit[k]}, {3'h0, PAT[63-k]});
        end
    endtask : run

    task complete_run;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (100000) @(posedge clk_i);
        fail_count++;
        complete_run;
    end

    initial begin
        clk_i = 1'b0;
        resetn_i = 1'b0;
        reg_addr_i = 16'h0000;
        reg_wdata_i = 8'h00;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        fail_count = 0;
        checked = 0;
        nrec = 64;
        vcount = 0;
        repeat (12) @(posedge clk_i);
        resetn_i <= 1'b1;
        reg_read(tbm_pkg::CTRL_ADDR, rd);
        check_reg(rd, 8'h00);
        reg_write(16'h0300, 8'hFF);
        reg_read(16'h0300, rd);
        check_reg(rd, 8'h00);
        for (int m = 0; m < 4; m++) begin
            reg_write(tbm_pkg::CTRL_ADDR, 8'(m));
            reg_read(tbm_pkg::CTRL_ADDR, rd);
            check_reg(rd, 8'(m));
        end
        reg_write(tbm_pkg::CTRL_ADDR, 8'h01);
        i_src.send_frame(2'h0, PAT);
        check_reg(8'(vcount), 8'h00);
        run(tbm_pkg::MODE_BIT_12M, 1'b0);
        run(tbm_pkg::MODE_BIT_16M, 1'b0);
        run(tbm_pkg::MODE_HMVIP, 1'b0);
        run(tbm_pkg::MODE_H100, 1'b0);
        run(tbm_pkg::MODE_BIT_12M, 1'b1);
        repeat (8) @(posedge clk_i);
        reg_read(tbm_pkg::FRAME_CNT_ADDR, rd);
        check_reg(rd, 8'h05);
        reg_read(tbm_pkg::STATUS_ADDR, rd);
        check_reg(rd, 8'h03);
        reg_write(tbm_pkg::STATUS_ADDR, 8'h01);
        reg_read(tbm_pkg::STATUS_ADDR, rd);
        check_reg(rd, 8'h02);
        // Reset again in mid-run: registers back to reset values
        @(posedge clk_i);
        resetn_i <= 1'b0;
        repeat (12) @(posedge clk_i);
        resetn_i <= 1'b1;
        reg_read(tbm_pkg::CTRL_ADDR, rd);
        check_reg(rd, 8'h00);
        reg_read(tbm_pkg::FRAME_CNT_ADDR, rd);
        check_reg(rd, 8'h00);
        complete_run;
    end
endmodule : tb_tx_backplane_mux_demux

`default_nettype wire
